//--- pkg/smbus_addr_defines.svh
`ifndef SMBUS_ADDR_DEFINES_SVH
`define SMBUS_ADDR_DEFINES_SVH

`define ADDR_SEL_LOW      7'h4C
`define ADDR_SEL_HIGH     7'h4E
`define ADDR_SEL_FLOAT    7'h4D
`define ALERT_RESP_ADDR   7'h0C
`define CONV_RATE_POR     8'h08
`define CMD_PTR_POR       8'h00
`define CONFIG_POR        8'h20
`define JTYPE_BIT         5
`define HIGH_LIMIT_POR    8'h46
`define LOW_LIMIT_POR     8'hC9
`define HYST_POR          8'h0A
`define CLK_PERIOD_NS     4
`define BUS_FREE_NS       4700
`define BUS_FREE_CYC      ((`BUS_FREE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- pkg/smbus_addr_pkg.sv
package smbus_addr_pkg;

    typedef enum logic [1:0] {
        SEL_LOW   = 2'b00,
        SEL_HIGH  = 2'b01,
        SEL_FLOAT = 2'b10
    } addr_sel_t;

    typedef struct packed {
        logic [7:0] high_temp_limit;
        logic [7:0] low_temp_limit;
        logic [7:0] hysteresis;
        logic [7:0] config_byte;
        logic [7:0] conv_rate;
        logic [7:0] cmd_ptr;
    } por_regs_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_AACK  = 3'b010,
        ST_SEND  = 3'b011,
        ST_MACK  = 3'b100,
        ST_SKIP  = 3'b101
    } link_state_t;

endpackage

//--- core/pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      pin_o
);
    logic meta_q;

    // first stage feeds only the second
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 1'b1;
            pin_o  <= 1'b1;
        end else begin
            meta_q <= pin_i;
            pin_o  <= meta_q;
        end
    end
endmodule

//--- core/addr_select_latch.sv
`timescale 1ns/100ps
`include "smbus_addr_defines.svh"
module addr_select_latch
    import smbus_addr_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       por_i,
    input  wire logic       has_select_i,
    input  wire addr_sel_t  sel_i,
    output logic [6:0]      target_addr_o
);
    function automatic logic [6:0] decode_sel(input addr_sel_t s);
        unique case (s)
            SEL_LOW:   decode_sel = `ADDR_SEL_LOW;
            SEL_HIGH:  decode_sel = `ADDR_SEL_HIGH;
            SEL_FLOAT: decode_sel = `ADDR_SEL_FLOAT;
            default:   decode_sel = `ADDR_SEL_LOW;
        endcase
    endfunction

    // select pin only looked at while power-on reset holds
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            target_addr_o <= `ADDR_SEL_LOW;
        end else if (por_i) begin
            target_addr_o <= has_select_i ? decode_sel(sel_i) : `ADDR_SEL_LOW;
        end
    end
endmodule

//--- core/smbus_address_por_defaults.sv
`timescale 1ns/100ps
`include "smbus_addr_defines.svh"
// Functional notes
// - parts without select pin answer only address 1001100 and the alert address.
// - select pin low, high, floating gives 1001100, 1001110, 1001101.
// - select pin sampled only during power-on reset, then held latched.
// - acknowledge reads to alert response address 0001100 too; this block acks them only while an alert is pending.
// - alert response byte is latched address in bits 7..1, bit 0 one.
// - supply dropout clears volatile registers back to power-up defaults.
// - no conversion may start while undervoltage lockout is active.
// - after power-up convert freely at 16 Hz in legacy resolution.
// - high and low temperature limits load fixed defaults at power-up.
// - interrupt latch cleared at power-up so alert starts released.
// - command pointer is 00h at power-up for quick receive byte.
// - hysteresis starts at 10 degrees.
// - junction type select starts at substrate PNP.
// - junction type select lives in configuration bit 5, one is PNP.
// - conversion-rate register resets to 08h, meaning 16 Hz.
module smbus_address_por_defaults
    import smbus_addr_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       por_i,
    input  wire logic       uvlo_i,
    input  wire logic       has_select_i,
    input  wire addr_sel_t  addr_sel_i,
    input  wire logic       alert_event_i,
    input  wire logic       conv_req_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            alert_n_o,
    output logic            conv_start_o,
    output logic            extended_res_o,
    output logic [6:0]      target_addr_o,
    output por_regs_t       regs_o
);
    logic       scl_s;
    logic       sda_s;
    logic       scl_prev_q;
    logic       sda_prev_q;
    logic [6:0] addr_w;
    logic       alert_pend_q;
    link_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic       ara_hit;

    pin_sync u_scl_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (scl_i),
        .pin_o      (scl_s)
    );

    pin_sync u_sda_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (sda_i),
        .pin_o      (sda_s)
    );

    addr_select_latch u_addr (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .por_i         (por_i),
        .has_select_i  (has_select_i),
        .sel_i         (addr_sel_i),
        .target_addr_o (addr_w)
    );

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            target_addr_o <= `ADDR_SEL_LOW;
        end else begin
            target_addr_o <= addr_w;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire start_c  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire stop_c   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // power-up register defaults; dropout reloads them all
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            regs_o.high_temp_limit <= `HIGH_LIMIT_POR;
            regs_o.low_temp_limit  <= `LOW_LIMIT_POR;
            regs_o.hysteresis      <= `HYST_POR;
            regs_o.config_byte     <= `CONFIG_POR;
            regs_o.conv_rate       <= `CONV_RATE_POR;
            regs_o.cmd_ptr         <= `CMD_PTR_POR;
        end else if (por_i) begin
            regs_o.high_temp_limit <= `HIGH_LIMIT_POR;
            regs_o.low_temp_limit  <= `LOW_LIMIT_POR;
            regs_o.hysteresis      <= `HYST_POR;
            regs_o.config_byte     <= `CONFIG_POR;
            regs_o.conv_rate       <= `CONV_RATE_POR;
            regs_o.cmd_ptr         <= `CMD_PTR_POR;
        end
    end

    // conversion starts follow the outside rate timer, gated by lockout
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            conv_start_o   <= 1'b0;
            extended_res_o <= 1'b0;
        end else begin
            conv_start_o   <= conv_req_i & ~uvlo_i & ~por_i;
            extended_res_o <= 1'b0;
        end
    end

    // event set wins over a clear by an alert response read
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            alert_pend_q <= 1'b0;
        end else if (por_i) begin
            alert_pend_q <= 1'b0;
        end else if (alert_event_i) begin
            alert_pend_q <= 1'b1;
        end else if (state_q == ST_MACK && scl_rise) begin
            alert_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            alert_n_o <= 1'b1;
        end else begin
            alert_n_o <= ~(alert_pend_q & ~por_i);
        end
    end

    // only the alert response read is served here; own-address traffic goes to the register engine
    assign ara_hit = (shift_q[6:0] == `ALERT_RESP_ADDR) & sda_s & alert_pend_q;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q   <= 8'h00;
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
        end else if (por_i || stop_c) begin
            state_q  <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end else if (start_c) begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 3'h0;
            sda_oe_o  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: ;
                ST_ADDR: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            state_q <= ara_hit ? ST_AACK : ST_SKIP;
                        end else begin
                            shift_q <= {shift_q[6:0], sda_s};
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        sda_o    <= 1'b0;
                        sda_oe_o <= ~sda_oe_o;
                        if (sda_oe_o) begin
                            state_q <= ST_SEND;
                            shift_q <= {target_addr_o, 1'b1};
                            sda_o   <= target_addr_o[6];
                            sda_oe_o <= 1'b1;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            state_q  <= ST_MACK;
                            sda_oe_o <= 1'b0;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sda_o   <= shift_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        state_q <= ST_SKIP;
                    end
                end
                ST_SKIP: ;
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- dv/smbus_addr_properties.sv
`timescale 1ns/100ps
`include "smbus_addr_defines.svh"
module smbus_addr_properties
    import smbus_addr_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic       por_i,
    input wire logic       uvlo_i,
    input wire logic       has_select_i,
    input wire addr_sel_t  addr_sel_i,
    input wire logic       alert_event_i,
    input wire logic       conv_req_i,
    input wire logic       sda_oe_o,
    input wire logic       alert_n_o,
    input wire logic       conv_start_o,
    input wire logic       extended_res_o,
    input wire logic [6:0] target_addr_o,
    input wire por_regs_t  regs_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    function automatic logic [6:0] dec(addr_sel_t s);
        return s == SEL_HIGH ? `ADDR_SEL_HIGH : s == SEL_FLOAT ? `ADDR_SEL_FLOAT : `ADDR_SEL_LOW;
    endfunction
    sequence s_por_fixed; (por_i && !has_select_i)[*3]; endsequence
    sequence s_por_sel; (por_i && has_select_i && $stable(addr_sel_i))[*3]; endsequence
    // the latch pipeline needs a few quiet cycles before it must freeze
    sequence s_run; (!por_i)[*4]; endsequence
    a_fixed_addr: assert property (s_por_fixed |=> target_addr_o == `ADDR_SEL_LOW)
        else $error("fixed address wrong");
    a_sel_decode: assert property (s_por_sel |=> target_addr_o == dec($past(addr_sel_i)))
        else $error("select decode wrong");
    a_addr_held: assert property (s_run |-> $stable(target_addr_o))
        else $error("address moved after power-on");
    a_por_defaults: assert property (por_i |=> regs_o == {`HIGH_LIMIT_POR, `LOW_LIMIT_POR, 8'h0A, 8'h20, 8'h08, 8'h00})
        else $error("defaults not reloaded");
    a_junction_pnp: assert property (por_i |=> regs_o.config_byte[5])
        else $error("junction type not substrate");
    a_alert_clear: assert property (por_i && !alert_event_i |=> alert_n_o)
        else $error("alert not cleared");
    a_conv_block: assert property (conv_start_o |-> $past(conv_req_i) && !$past(uvlo_i) && !$past(por_i))
        else $error("conversion started in lockout");
    a_conv_issue: assert property (conv_req_i && !uvlo_i && !por_i |=> conv_start_o)
        else $error("conversion request dropped");
    a_legacy_res: assert property (!extended_res_o)
        else $error("extended resolution set");
    a_ack_pending: assert property ($rose(sda_oe_o) |-> !alert_n_o)
        else $error("answered without pending alert");
endmodule
bind smbus_address_por_defaults smbus_addr_properties i_props (.core_clk_i, .rst_i, .por_i, .uvlo_i,
    .has_select_i, .addr_sel_i, .alert_event_i, .conv_req_i, .sda_oe_o, .alert_n_o, .conv_start_o,
    .extended_res_o, .target_addr_o, .regs_o);

//--- dv/smbus_host_model.sv
`timescale 1ns/100ps
`include "smbus_addr_defines.svh"
module smbus_host_model (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // clock parked high and data released between frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic bit_x(input logic b, output logic r);
        sda_low_o = !b;
        // quarter steps split 31.3/31.2 so a bit lasts exactly 125 ns at this precision
        #31.3 scl_o = 1'b1;
        #31.2 r = sda_i;
        #31.3 scl_o = 1'b0;
        #31.2;
    endtask
    task automatic alert_read(output logic ack, output logic [7:0] data);
        logic [7:0] a;
        logic n;
        a = {`ALERT_RESP_ADDR, 1'b1};
        data = 8'hFF;
        sda_low_o = 1'b1;
        #62.5 scl_o = 1'b0;
        #31.25;
        for (int i = 7; i >= 0; i--) bit_x(a[i], n);
        bit_x(1'b1, ack);
        if (!ack) begin
            for (int i = 7; i >= 0; i--) bit_x(1'b1, data[i]);
            bit_x(1'b1, n);
        end
        sda_low_o = 1'b1;
        #31.25 scl_o = 1'b1;
        #31.25 sda_low_o = 1'b0;
        #62.5;
    endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/100ps
`include "smbus_addr_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module testbench
    import smbus_addr_pkg::*;
;
    logic       core_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       por_i, uvlo_i, has_select_i, alert_event_i, conv_req_i;
    addr_sel_t  addr_sel_i;
    logic       scl, sda_low, sda_o, sda_oe_o, alert_n_o, conv_start_o, extended_res_o;
    logic [6:0] target_addr_o;
    por_regs_t  regs_o;
    int         num_errors = 0;
    int         n_compared = 0;
    // pulled-up line: low if anyone drives it
    wire        sda_line = ~(sda_low | (sda_oe_o & ~sda_o));
    always #2 core_clk_i = ~core_clk_i;
    smbus_address_por_defaults i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .por_i(por_i), .uvlo_i(uvlo_i),
        .has_select_i(has_select_i), .addr_sel_i(addr_sel_i), .alert_event_i(alert_event_i),
        .conv_req_i(conv_req_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .alert_n_o(alert_n_o), .conv_start_o(conv_start_o), .extended_res_o(extended_res_o),
        .target_addr_o(target_addr_o), .regs_o(regs_o));
    smbus_host_model i_host (.sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check_defaults;
        `CHK(regs_o.high_temp_limit, `HIGH_LIMIT_POR)
        `CHK(regs_o.low_temp_limit, `LOW_LIMIT_POR)
        `CHK(regs_o.hysteresis, 8'h0A)
        `CHK(regs_o.config_byte, 8'h20)
        `CHK(regs_o.conv_rate, 8'h08)
        `CHK(regs_o.cmd_ptr, 8'h00)
        `CHK(alert_n_o, 1'b1)
        `CHK(extended_res_o, 1'b0)
    endtask
    task automatic t_addr;
        logic [6:0] exp [4] = '{7'h4C, 7'h4E, 7'h4D, 7'h4C};
        for (int i = 0; i < 4; i++) begin
            has_select_i = (i < 3);
            addr_sel_i = (i == 3) ? SEL_HIGH : addr_sel_t'(i);
            por_i = 1'b1;
            step(4);
            por_i = 1'b0;
            step(3);
            addr_sel_i = (addr_sel_i == SEL_HIGH) ? SEL_LOW : SEL_HIGH;
            step(4);
            `CHK(target_addr_o, exp[i])
        end
    endtask
    task automatic t_conv;
        uvlo_i = 1'b1;
        conv_req_i = 1'b1;
        step(1);
        `CHK(conv_start_o, 1'b0)
        uvlo_i = 1'b0;
        step(1);
        `CHK(conv_start_o, 1'b1)
        por_i = 1'b1;
        step(1);
        `CHK(conv_start_o, 1'b0)
        por_i = 1'b0;
        step(1);
        `CHK(conv_start_o, 1'b1)
        uvlo_i = 1'b1;
        step(1);
        `CHK(conv_start_o, 1'b0)
        conv_req_i = 1'b0;
        uvlo_i = 1'b0;
        step(1);
        `CHK(conv_start_o, 1'b0)
    endtask
    task automatic t_ara;
        logic       ack;
        logic [7:0] d;
        has_select_i = 1'b1;
        addr_sel_i = SEL_HIGH;
        por_i = 1'b1;
        step(4);
        por_i = 1'b0;
        step(4);
        i_host.alert_read(ack, d);
        step(1);
        `CHK(ack, 1'b1)
        alert_event_i = 1'b1;
        step(1);
        alert_event_i = 1'b0;
        step(2);
        `CHK(alert_n_o, 1'b0)
        i_host.alert_read(ack, d);
        step(1);
        `CHK(ack, 1'b0)
        `CHK(d, {7'h4E, 1'b1})
        `CHK(alert_n_o, 1'b1)
        alert_event_i = 1'b1;
        step(1);
        alert_event_i = 1'b0;
        step(2);
        // dropout while an alert is still pending; select moved so the relatch shows
        addr_sel_i = SEL_FLOAT;
        por_i = 1'b1;
        step(2);
        por_i = 1'b0;
        step(2);
        check_defaults;
        `CHK(target_addr_o, 7'h4D)
    endtask
    initial begin
        {por_i, uvlo_i, has_select_i, alert_event_i, conv_req_i} = '0;
        addr_sel_i = SEL_LOW;
        step(10);
        rst_i = 1'b0;
        step(2);
        check_defaults;
        `CHK(target_addr_o, 7'h4C)
        t_addr;
        t_conv;
        t_ara;
        tally_and_finish;
    end
    initial begin
        #100000;
        num_errors++;
        tally_and_finish;
    end
endmodule
